/* File: logic/sts_consts.vh */
// Constants for the satellite time status and offset block
`ifndef STS_CONSTS_VH
`define STS_CONSTS_VH

// Clock and time base
`define STS_CLK_HZ 100000000
`define STS_TICK_US 1000
`define STS_MS_CYCLES (`STS_CLK_HZ / 1000000 * `STS_TICK_US)
`define STS_MS_MAX 10'h3e7
`define STS_BLINK_MS 10'h1f4

// Calendar limits
`define STS_SEC_MAX 6'h3b
`define STS_MIN_MAX 6'h3b
`define STS_HOUR_MAX 5'h17
`define STS_HOURS_DAY 5'h18
`define STS_DAY_MAX 9'h16e
`define STS_DAY_MIN 9'h001

// Lock and drift thresholds in seconds
`define STS_LOSS_S 150
`define STS_LOSS_CNT 8'h96
`define STS_DRIFT1_S 9000
`define STS_DRIFT1_CNT 16'h2328
`define STS_DRIFT2_S 54000
`define STS_DRIFT2_CNT 16'hd2f0

// Delay switch neutral setting in ms
`define STS_DLY_ZERO 7'h32

// Register offsets
`define STS_REG_CFG 12'h000
`define STS_REG_STAT 12'h004
`define STS_REG_TIME 12'h008

// Config field positions
`define STS_CFG_OFF_LSB 0
`define STS_CFG_H12 5
`define STS_CFG_EAST 6
`define STS_CFG_WEST 7
`define STS_CFG_UNITS_LSB 8
`define STS_CFG_TENS_LSB 12
`define STS_CFG_RESET 16'h5000

`endif

/* File: logic/sts_sync3.v */
// Three flip-flop input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module sts_sync3 #(
    parameter W = 3
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Asynchronous inputs
    input wire [W-1:0] async_in,
    // Filtered synchronous levels
    output reg [W-1:0] sync_out
);

reg [W-1:0] stage1;
reg [W-1:0] stage2;
reg [W-1:0] stage3;
integer i;

// Shift chain; output follows once second and third agree
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stage1 <= {W{1'b0}};
        stage2 <= {W{1'b0}};
        stage3 <= {W{1'b0}};
        sync_out <= {W{1'b0}};
    end else begin
        stage1 <= async_in;
        stage2 <= stage1;
        stage3 <= stage2;
        for (i = 0; i < W; i = i + 1) begin
            if (stage2[i] == stage3[i]) begin
                sync_out[i] <= stage3[i];
            end
        end
    end
end

endmodule
`default_nettype wire

/* File: logic/sts_top.v */
// Satellite clock status, offset, format and delay correction logic
//
// Summary of operation
// - Satellite indicator lit while data-rate locked
// - Indicator off after 150 s lock loss
// - Relight only after position field recognised
// - Position mismatch blinks indicator chosen by carrier
// - Auto mode mismatch blink armed only after first full sync
// - Display blanked from power-up until valid
// - Display on after locks and agreeing frames
// - Time shown as day, hour, minute, second
// - Colons flash after 2.5 h unlocked drift
// - Whole display flashes after 15 h drift
// - Flashing stops when time code resynchronised
// - Signed hours offset added to UTC hours
// - Time outputs carry same adjusted value
// - 24-hour default, 12-hour when selected
// - Select bits force east, west, else scan
// - Automatic scanning when neither force set
// - Delay from tens and units digits, ms
// - Fifty neutral, each step one millisecond
// - Delay shifts display, outputs and marks alike
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "sts_consts.vh"

module sts_top #(
    parameter MS_CYCLES = `STS_MS_CYCLES
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Receiver lock pins, asynchronous
    input wire carrier_lock_pin,
    input wire rate_lock_pin,
    input wire carrier_high_pin,
    // Decoded frame from demodulator, pclk domain
    input wire frame_stb,
    input wire [8:0] frame_day,
    input wire [4:0] frame_hour,
    input wire [5:0] frame_min,
    input wire [5:0] frame_sec,
    input wire pos_stb,
    input wire pos_east,
    // Satellite selection to receiver
    output reg force_east,
    output reg force_west,
    output reg auto_scan,
    // Display and time outputs
    output reg [8:0] disp_day,
    output reg [4:0] disp_hour,
    output reg [5:0] disp_min,
    output reg [5:0] disp_sec,
    output reg disp_pm,
    output reg disp_blank,
    output reg colon_on,
    output reg time_valid,
    output reg sec_mark,
    // Front panel indicators
    output reg led_east,
    output reg led_west
);

// Clamp a switch digit to 0..9
function [3:0] digit;
    input [3:0] d;
    begin
        digit = (d > 4'h9) ? 4'h9 : d;
    end
endfunction

// Synchronised receiver levels
wire [2:0] pins_s;
sts_sync3 #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({carrier_high_pin, rate_lock_pin, carrier_lock_pin}),
    .sync_out(pins_s)
);
wire carrier_lock = pins_s[0];
wire rate_lock = pins_s[1];
wire carrier_high = pins_s[2];

// Register file
reg [15:0] cfg;
wire [4:0] hr_off = cfg[`STS_CFG_OFF_LSB +: 5];
wire h12 = cfg[`STS_CFG_H12];
wire [3:0] d_units = digit(cfg[`STS_CFG_UNITS_LSB +: 4]);
wire [3:0] d_tens = digit(cfg[`STS_CFG_TENS_LSB +: 4]);
wire [6:0] dly = {d_tens, 3'b000} + {2'b00, d_tens, 1'b0} + {3'b000, d_units};
wire [6:0] dly_ret = `STS_DLY_ZERO - dly;
wire [31:0] stat_word;
wire [31:0] time_word;
wire addr_ok = (paddr == `STS_REG_CFG) || (paddr == `STS_REG_STAT) ||
               (paddr == `STS_REG_TIME);

assign pready = 1'b1;
assign pslverr = psel & penable & ~addr_ok;

// Config writes in access phase, read data capture in setup phase
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cfg <= `STS_CFG_RESET;
        prdata <= 32'h00000000;
    end else begin
        if (psel && penable && pwrite && paddr == `STS_REG_CFG) begin
            cfg <= pwdata[15:0];
        end
        if (psel && !penable) begin
            case (paddr)
                `STS_REG_CFG: prdata <= {16'h0000, cfg};
                `STS_REG_STAT: prdata <= stat_word;
                `STS_REG_TIME: prdata <= time_word;
                default: prdata <= 32'h00000000;
            endcase
        end
    end
end

// Selection outputs to receiver
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        force_east <= 1'b0;
        force_west <= 1'b0;
        auto_scan <= 1'b1;
    end else begin
        force_east <= cfg[`STS_CFG_EAST];
        force_west <= cfg[`STS_CFG_WEST] & ~cfg[`STS_CFG_EAST];
        auto_scan <= ~cfg[`STS_CFG_EAST] & ~cfg[`STS_CFG_WEST];
    end
end

// Millisecond divider
reg [16:0] div_cnt;
wire ms_tick = (div_cnt == MS_CYCLES[16:0] - 17'h00001);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        div_cnt <= 17'h00000;
    end else if (ms_tick) begin
        div_cnt <= 17'h00000;
    end else begin
        div_cnt <= div_cnt + 17'h00001;
    end
end

// Time of year counter
reg [9:0] ms;
reg [5:0] sec;
reg [5:0] minute;
reg [4:0] hour;
reg [8:0] day;
wire sec_tick = ms_tick && (ms == `STS_MS_MAX);
wire blink = (ms < `STS_BLINK_MS);

// Held frame and delayed load
reg [8:0] f_day;
reg [4:0] f_hour;
reg [5:0] f_min;
reg [5:0] f_sec;
reg ld_pend;
reg [5:0] wait_cnt;
reg [9:0] ld_ms;
reg cand;
wire load = ld_pend && (wait_cnt == 6'h00);
wire match = cand && sec == f_sec && minute == f_min && hour == f_hour && day == f_day;
wire sync_ev = load && match && carrier_lock && rate_lock;

// Frame capture; retarding settings wait, advancing ones preload ms
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        f_day <= `STS_DAY_MIN;
        {f_hour, f_min, f_sec} <= 17'h00000;
        {ld_pend, wait_cnt, ld_ms, cand} <= 18'h00000;
    end else begin
        if (frame_stb) begin
            f_day <= frame_day;
            f_hour <= frame_hour;
            f_min <= frame_min;
            f_sec <= frame_sec;
            ld_pend <= 1'b1;
            if (dly >= `STS_DLY_ZERO) begin
                wait_cnt <= 6'h00;
                ld_ms <= {3'b000, dly - `STS_DLY_ZERO};
            end else begin
                wait_cnt <= dly_ret[5:0];
                ld_ms <= 10'h000;
            end
        end else if (load) begin
            ld_pend <= 1'b0;
            cand <= carrier_lock & rate_lock;
        end else if (ld_pend && ms_tick) begin
            wait_cnt <= wait_cnt - 6'h01;
        end
    end
end

// Running time; delay correction lands here so all views follow
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        {ms, sec, minute, hour} <= 27'h0000000;
        day <= `STS_DAY_MIN;
    end else if (load) begin
        ms <= ld_ms;
        sec <= f_sec;
        minute <= f_min;
        hour <= f_hour;
        day <= f_day;
    end else if (ms_tick) begin
        if (ms != `STS_MS_MAX) begin
            ms <= ms + 10'h001;
        end else begin
            ms <= 10'h000;
            if (sec != `STS_SEC_MAX) begin
                sec <= sec + 6'h01;
            end else begin
                sec <= 6'h00;
                if (minute != `STS_MIN_MAX) begin
                    minute <= minute + 6'h01;
                end else begin
                    minute <= 6'h00;
                    if (hour != `STS_HOUR_MAX) begin
                        hour <= hour + 5'h01;
                    end else begin
                        hour <= 5'h00;
                        day <= (day == `STS_DAY_MAX) ? `STS_DAY_MIN : day + 9'h001;
                    end
                end
            end
        end
    end
end

// Display enable and drift accumulation
reg disp_on;
reg [15:0] drift;
wire colon_flash = (drift >= `STS_DRIFT1_CNT);
wire all_flash = (drift >= `STS_DRIFT2_CNT);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        disp_on <= 1'b0;
        drift <= 16'h0000;
    end else begin
        if (sync_ev) begin
            disp_on <= 1'b1;
            drift <= 16'h0000;
        end else if (sec_tick && disp_on && !rate_lock && !all_flash) begin
            drift <= drift + 16'h0001;
        end
    end
end

// Satellite indicator state
reg sat_lit;
reg need_pos;
reg cur_east;
reg exp_east;
reg exp_valid;
reg [7:0] loss_sec;
wire forced = cfg[`STS_CFG_EAST] | cfg[`STS_CFG_WEST];
wire want_east = forced ? cfg[`STS_CFG_EAST] : exp_east;
wire mis = sat_lit && (cand || disp_on) && (forced || exp_valid) &&
           (cur_east != want_east);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        {sat_lit, cur_east, exp_east, exp_valid} <= 4'h0;
        need_pos <= 1'b1;
        loss_sec <= 8'h00;
    end else begin
        if (rate_lock) begin
            loss_sec <= 8'h00;
        end else if (sec_tick && loss_sec != `STS_LOSS_CNT) begin
            loss_sec <= loss_sec + 8'h01;
        end
        if (!rate_lock && loss_sec == `STS_LOSS_CNT) begin
            sat_lit <= 1'b0;
            need_pos <= 1'b1;
        end else if (pos_stb && rate_lock) begin
            cur_east <= pos_east;
            need_pos <= 1'b0;
            sat_lit <= 1'b1;
        end else if (rate_lock && !need_pos) begin
            sat_lit <= 1'b1;
        end
        if (sync_ev && !forced) begin
            exp_east <= cur_east;
            exp_valid <= 1'b1;
        end
    end
end

// Hours offset with day borrow and carry
reg signed [6:0] hs;
reg [4:0] h24;
reg [8:0] dadj;
reg [4:0] hshow;
reg pm;
always @* begin
    hs = $signed({2'b00, hour}) + $signed({{2{hr_off[4]}}, hr_off});
    h24 = hs[4:0];
    dadj = day;
    if (hs < 0) begin
        h24 = hs[4:0] + `STS_HOURS_DAY;
        dadj = (day == `STS_DAY_MIN) ? `STS_DAY_MAX : day - 9'h001;
    end else if (hs > $signed({2'b00, `STS_HOUR_MAX})) begin
        h24 = hs[4:0] - `STS_HOURS_DAY;
        dadj = (day == `STS_DAY_MAX) ? `STS_DAY_MIN : day + 9'h001;
    end
    pm = (h24 >= 5'h0c);
    hshow = h24;
    if (h12) begin
        if (h24 == 5'h00) begin
            hshow = 5'h0c;
        end else if (h24 > 5'h0c) begin
            hshow = h24 - 5'h0c;
        end
    end
end

// Registered display, time outputs and indicators
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        {disp_day, disp_hour, disp_min, disp_sec, disp_pm} <= 27'h0000000;
        disp_blank <= 1'b1;
        {colon_on, time_valid, sec_mark, led_east, led_west} <= 5'h00;
    end else begin
        disp_day <= dadj;
        disp_hour <= hshow;
        disp_min <= minute;
        disp_sec <= sec;
        disp_pm <= h12 & pm;
        disp_blank <= ~disp_on | (all_flash & blink);
        colon_on <= disp_on ? ~(colon_flash & blink) : (cand | blink);
        time_valid <= disp_on;
        sec_mark <= sec_tick & disp_on;
        if (mis) begin
            led_east <= carrier_high & blink;
            led_west <= ~carrier_high & blink;
        end else begin
            led_east <= sat_lit & cur_east;
            led_west <= sat_lit & ~cur_east;
        end
    end
end

// Status and time readback words
assign stat_word = {22'h000000, mis, need_pos, sat_lit, cand, all_flash, colon_flash,
                    disp_on, carrier_high, rate_lock, carrier_lock};
assign time_word = {dadj, disp_pm, h24, 5'h00, minute, sec};

endmodule
`default_nettype wire

/* File: tb/sts_top_chk.sv */
// Port checker for the satellite time status block
`timescale 1ns/1ns
`default_nettype none
module sts_top_chk #(
    parameter MS_CYCLES = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Lock pins
    input wire logic carrier_lock_pin,
    input wire logic rate_lock_pin,
    // Selection, display and indicators
    input wire logic force_east,
    input wire logic force_west,
    input wire logic auto_scan,
    input wire logic [8:0] disp_day,
    input wire logic [4:0] disp_hour,
    input wire logic [5:0] disp_min,
    input wire logic [5:0] disp_sec,
    input wire logic disp_pm,
    input wire logic disp_blank,
    input wire logic time_valid,
    input wire logic sec_mark,
    input wire logic led_east,
    input wire logic led_west
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    blank_until_on_a: assert property (!time_valid |-> disp_blank)
        else $error("display lit before valid time");
    display_stays_a: assert property (time_valid |=> time_valid)
        else $error("display enable dropped");
    lock_before_on_a: assert property (
        $rose(time_valid) |-> carrier_lock_pin && rate_lock_pin)
        else $error("display enabled without both locks");
    select_mode_a: assert property (
        auto_scan != (force_east || force_west) && !(force_east && force_west))
        else $error("satellite selection outputs inconsistent");
    time_range_a: assert property (
        disp_hour <= 5'h17 && disp_min <= 6'h3b && disp_sec <= 6'h3b)
        else $error("displayed time field out of range");
    day_range_a: assert property (
        time_valid |-> disp_day >= 9'h001 && disp_day <= 9'h16e)
        else $error("displayed day out of range");
    pm_hour_a: assert property (disp_pm |-> disp_hour >= 5'h01 && disp_hour <= 5'h0c)
        else $error("twelve hour value out of range");
    sec_pulse_a: assert property (sec_mark |-> time_valid ##1 !sec_mark [*8])
        else $error("second mark malformed");
    one_led_a: assert property (!(led_east && led_west))
        else $error("both indicators lit");
endmodule
bind sts_top sts_top_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (.pclk, .presetn, .carrier_lock_pin,
    .rate_lock_pin, .force_east, .force_west, .auto_scan, .disp_day, .disp_hour, .disp_min,
    .disp_sec, .disp_pm, .disp_blank, .time_valid, .sec_mark, .led_east, .led_west);
`default_nettype wire

/* File: tb/sts_rx_model.sv */
// Receiver side model: lock pins, decoded frames, position strobes
`timescale 1ns/1ns
`default_nettype none
module sts_rx_model (
    // Clock
    input wire logic pclk,
    // Lock levels
    output logic carrier_lock_pin,
    output logic rate_lock_pin,
    output logic carrier_high_pin,
    // Frame and position
    output logic frame_stb,
    output logic [8:0] frame_day,
    output logic [4:0] frame_hour,
    output logic [5:0] frame_min,
    output logic [5:0] frame_sec,
    output logic pos_stb,
    output logic pos_east
);
    // Unlocked and idle at power-up
    initial begin
        {carrier_lock_pin, rate_lock_pin, carrier_high_pin, frame_stb, pos_stb} = 5'h00;
        {frame_day, frame_hour, frame_min, frame_sec, pos_east} = 27'h0;
    end
    // Lock levels
    task automatic locks(input logic c, input logic r, input logic h);
        @(posedge pclk);
        {carrier_lock_pin, rate_lock_pin, carrier_high_pin} <= {c, r, h};
    endtask
    // Frame mark; fields scrambled outside the strobe
    task automatic frame(input logic [8:0] d, input logic [4:0] h,
        input logic [5:0] m, input logic [5:0] s);
        @(posedge pclk);
        frame_stb <= 1'b1;
        {frame_day, frame_hour, frame_min, frame_sec} <= {d, h, m, s};
        @(posedge pclk);
        frame_stb <= 1'b0;
        {frame_day, frame_hour, frame_min, frame_sec} <= ~{d, h, m, s};
    endtask
    // Position field recognised
    task automatic pos(input logic e);
        @(posedge pclk);
        {pos_stb, pos_east} <= {1'b1, e};
        @(posedge pclk);
        {pos_stb, pos_east} <= {1'b0, ~e};
    endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Testbench for the satellite time status and offset block
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int MS = 2;
    logic pclk, presetn, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    int errors, checks, n, n0;
    wire [31:0] prdata;
    wire pready, pslverr, carrier_lock_pin, rate_lock_pin, carrier_high_pin;
    wire frame_stb, pos_stb, pos_east, force_east, force_west, auto_scan, disp_pm;
    wire disp_blank, colon_on, time_valid, sec_mark, led_east, led_west;
    wire [8:0] frame_day, disp_day;
    wire [4:0] frame_hour, disp_hour;
    wire [5:0] frame_min, frame_sec, disp_min, disp_sec;
    logic [15:0] sc [4] = '{16'h5040, 16'h5080, 16'h50c0, 16'h5000};
    logic [2:0] ss [4] = '{3'h4, 3'h2, 3'h4, 3'h1};
    logic [15:0] oc [5] = '{16'h5014, 16'h5005, 16'h5025, 16'h5036, 16'h5000};
    logic [14:0] ed [5] = '{15'h18d6, 15'h190f, 15'h1923, 15'h190c, 15'h190a};
    logic [14:0] et [5] = '{15'h18d6, 15'h190f, 15'h192f, 15'h1900, 15'h190a};
    logic [15:0] dc [5] = '{16'h5000, 16'h6200, 16'h3200, 16'h9900, 16'hf500};
    int dv [5] = '{50, 62, 32, 99, 95};
    sts_top #(.MS_CYCLES(MS)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .carrier_lock_pin, .rate_lock_pin, .carrier_high_pin,
        .frame_stb, .frame_day, .frame_hour, .frame_min, .frame_sec, .pos_stb, .pos_east,
        .force_east, .force_west, .auto_scan, .disp_day, .disp_hour, .disp_min, .disp_sec,
        .disp_pm, .disp_blank, .colon_on, .time_valid, .sec_mark, .led_east, .led_west);
    sts_rx_model i_rx (.pclk, .carrier_lock_pin, .rate_lock_pin, .carrier_high_pin, .frame_stb,
        .frame_day, .frame_hour, .frame_min, .frame_sec, .pos_stb, .pos_east);
    // Clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One bus transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (90000) @(posedge pclk);
        errors++;
        test_done;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        cmp("blank", 1, disp_blank);
        cmp("auto", 1, auto_scan);
        apb(0, 12'h000, 0);
        cmp("cfg", 32'h5000, rd);
        apb(0, 12'h00c, 0);
        cmp("slverr", 1, err);
        cmp("unmapped", 0, rd);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            apb(1, 12'h000, {16'h0, sc[i]});
            repeat (3) @(posedge pclk);
            cmp("select", ss[i], {force_east, force_west, auto_scan});
        end
        $display("test select done");
        i_rx.locks(1'b1, 1'b1, 1'b0);
        repeat (10) @(posedge pclk);
        cmp("east before pos", 0, led_east);
        i_rx.pos(1'b1);
        repeat (3) @(posedge pclk);
        cmp("east lit", 1, led_east);
        i_rx.frame(9'd100, 5'd10, 6'd20, 6'd0);
        repeat (30500 * MS) @(posedge pclk);
        cmp("one frame", 0, time_valid);
        i_rx.frame(9'd100, 5'd10, 6'd20, 6'd30);
        for (n = 0; n < 99 && time_valid !== 1'b1; n++) @(posedge pclk);
        cmp("valid", 1, time_valid);
        cmp("lit", 0, disp_blank);
        cmp("time", {9'd100, 5'd10, 6'd20, 6'd30}, {disp_day, disp_hour, disp_min, disp_sec});
        cmp("colon", 1, colon_on);
        $display("test sync done");
        for (int i = 0; i < 5; i++) begin
            apb(1, 12'h000, {16'h0, oc[i]});
            repeat (3) @(posedge pclk);
            cmp("disp", ed[i], {disp_day, disp_pm, disp_hour});
            apb(0, 12'h008, 0);
            cmp("out", et[i], rd[31:17]);
        end
        $display("test offset done");
        for (int i = 0; i < 5; i++) begin
            apb(1, 12'h000, {16'h0, dc[i]});
            i_rx.frame(9'd100, 5'd10, 6'd21, 6'd0);
            for (n = 0; n < 5000 && sec_mark !== 1'b1; n++) @(posedge pclk);
            if (i == 0) n0 = n;
            cmp("delay", 1, (n - n0 - (50 - dv[i]) * MS) inside {[-1:1]});
        end
        $display("test delay done");
        // Forced west with east decoded, then auto after sweeping west on high carrier
        for (int i = 0; i < 2; i++) begin
            apb(1, 12'h000, i ? 32'h5000 : 32'h5080);
            i_rx.locks(1'b1, 1'b1, i[0]);
            i_rx.pos(!i[0]);
            repeat (8) @(posedge pclk);
            n = 0;
            repeat (1000 * MS) begin
                @(posedge pclk);
                n += i ? led_east : led_west;
            end
            cmp("blink", 1, n inside {[490 * MS:510 * MS]});
            cmp("other dark", 0, i ? led_west : led_east);
        end
        $display("test blink done");
        test_done;
    end
endmodule
`default_nettype wire
